// >>> isp_map.svh
// Constants for the serial programming host: opcodes, field positions and timing
`ifndef ISP_MAP_SVH
`define ISP_MAP_SVH

`define ISP_CLK_NS          4
`define ISP_CYC(ns)         (((ns) + `ISP_CLK_NS - 1) / `ISP_CLK_NS)
`define ISP_WAIT_W          23
`define ISP_STARTUP_NS      20000000
`define ISP_PAGE_WAIT_NS    2600000
`define ISP_EE_WAIT_NS      3600000
`define ISP_ERASE_WAIT_NS   10500000
`define ISP_FUSE_WAIT_NS    4500000
`define ISP_RST_PULSE_NS    1000
`define ISP_SCK_HALF        4
`define ISP_PH_W            3
`define ISP_FRAME_BITS      32
`define ISP_ECHO_MSB        15
`define ISP_ECHO_LSB        8

`define ISP_B1_PROG         8'hAC
`define ISP_B2_ENABLE       8'h53
`define ISP_B2_ERASE        8'h80
`define ISP_B2_LOCK         8'hE0
`define ISP_B2_FUSE_LO      8'hA0
`define ISP_B2_FUSE_HI      8'hA8
`define ISP_B2_FUSE_EXT     8'hA4
`define ISP_B2_SEL_HI       8'h08
`define ISP_B1_POLL         8'hF0
`define ISP_B1_LOAD_EXT     8'h4D
`define ISP_B1_LOAD_HI      8'h48
`define ISP_B1_LOAD_LO      8'h40
`define ISP_B1_LOAD_EE      8'hC1
`define ISP_B1_READ_HI      8'h28
`define ISP_B1_READ_LO      8'h20
`define ISP_B1_READ_EE      8'hA0
`define ISP_B1_READ_58      8'h58
`define ISP_B1_READ_50      8'h50
`define ISP_B1_READ_SIG     8'h30
`define ISP_B1_READ_CAL     8'h38
`define ISP_B1_WRITE_PAGE   8'h4C
`define ISP_B1_WRITE_EE     8'hC0
`define ISP_B1_WRITE_EE_PG  8'hC2
`define ISP_ZERO            8'h00

`endif

// >>> isp_pkg.sv
// Types shared by the serial programming host
package isp_pkg;

    typedef enum logic [4:0] {
        ISP_OP_ENABLE, ISP_OP_ERASE, ISP_OP_POLL, ISP_OP_LOAD_EXT,
        ISP_OP_LOAD_LO, ISP_OP_LOAD_HI, ISP_OP_LOAD_EE, ISP_OP_READ_LO,
        ISP_OP_READ_HI, ISP_OP_READ_EE, ISP_OP_READ_LOCK, ISP_OP_READ_SIG,
        ISP_OP_READ_FUSE_LO, ISP_OP_READ_FUSE_HI, ISP_OP_READ_FUSE_EXT, ISP_OP_READ_CAL,
        ISP_OP_WRITE_PAGE, ISP_OP_WRITE_EE, ISP_OP_WRITE_EE_PAGE, ISP_OP_WRITE_LOCK,
        ISP_OP_WRITE_FUSE_LO, ISP_OP_WRITE_FUSE_HI, ISP_OP_WRITE_FUSE_EXT, ISP_OP_END
    } isp_op_t;

    typedef struct packed {
        isp_op_t     op;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        poll;
    } isp_cmd_t;

    typedef struct packed {
        isp_op_t     op;
        logic [7:0]  data;
        logic        echo_ok;
        logic        busy;
        logic        refused;
    } isp_rsp_t;

    typedef enum logic [2:0] {
        ISP_ST_PWRUP = 3'h0,
        ISP_ST_IDLE  = 3'h1,
        ISP_ST_SHIFT = 3'h3,
        ISP_ST_DONE  = 3'h2,
        ISP_ST_RSTP  = 3'h6
    } isp_state_t;

endpackage

// >>> isp_sync.sv
// Two-flop synchroniser for the serial data returned by the target
`timescale 1ns/1ps
module isp_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic din,
    output logic      dout
);
    logic meta_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            dout   <= 1'b0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // isp_sync

// >>> isp_wait.sv
// Down-counter for the startup, reset pulse and write wait delays
`timescale 1ns/1ps
`include "isp_map.svh"
module isp_wait (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   load,
    input  wire logic [`ISP_WAIT_W-1:0] count,
    output logic                        busy
);
    logic [`ISP_WAIT_W-1:0] cnt_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (load) begin
            cnt_q <= count;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign busy = (cnt_q != '0);
endmodule // isp_wait

// >>> isp_host.sv
// Serial programming host: frames instructions, drives the target pins, paces writes
`timescale 1ns/1ps
`include "isp_map.svh"
module isp_host #(
    parameter logic [`ISP_WAIT_W-1:0] STARTUP_CYC    = `ISP_WAIT_W'(`ISP_CYC(`ISP_STARTUP_NS)),
    parameter logic [`ISP_WAIT_W-1:0] PAGE_WAIT_CYC  = `ISP_WAIT_W'(`ISP_CYC(`ISP_PAGE_WAIT_NS)),
    parameter logic [`ISP_WAIT_W-1:0] EE_WAIT_CYC    = `ISP_WAIT_W'(`ISP_CYC(`ISP_EE_WAIT_NS)),
    parameter logic [`ISP_WAIT_W-1:0] ERASE_WAIT_CYC = `ISP_WAIT_W'(`ISP_CYC(`ISP_ERASE_WAIT_NS)),
    parameter logic [`ISP_WAIT_W-1:0] FUSE_WAIT_CYC  = `ISP_WAIT_W'(`ISP_CYC(`ISP_FUSE_WAIT_NS)),
    parameter logic [7:0]             UNUSED_MASK    = 8'h00
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               cmd_valid,
    input  wire isp_pkg::isp_cmd_t  cmd,
    output isp_pkg::isp_rsp_t       rsp,
    output logic                    cmd_ready,
    output logic                    rsp_valid,
    output logic                    session_active,
    output logic                    target_rst_n,
    output logic                    sck,
    output logic                    mosi,
    input  wire logic               miso
);
    import isp_pkg::*;

    localparam logic [`ISP_WAIT_W-1:0] RST_PULSE_CYC = `ISP_WAIT_W'(`ISP_CYC(`ISP_RST_PULSE_NS));
    localparam logic [`ISP_PH_W-1:0]   PH_LAST       = `ISP_PH_W'(`ISP_SCK_HALF - 1);
    localparam logic [4:0]             BIT_LAST      = 5'(`ISP_FRAME_BITS - 1);

    isp_state_t             state_q;
    isp_cmd_t               cmd_q;
    isp_rsp_t               rsp_q;
    logic                   ready_q, rsp_valid_q, enabled_q, rst_out_q, sck_q, mosi_q;
    logic                   armed_q, pend_q, lo_valid_q;
    logic [5:0]             lo_addr_q;
    logic [31:0]            tx_q, rx_q;
    logic [`ISP_PH_W-1:0]   ph_q;
    logic [4:0]             bit_q;
    logic                   miso_s, wait_busy, wait_load;
    logic [`ISP_WAIT_W-1:0] wait_count;
    logic                   take, need_pwr, refuse, start, pwr_done, go, frame_end, echo_ok;
    logic                   rstp_done;
    isp_cmd_t               go_cmd;
    logic [31:0]            go_frame;

    function automatic logic is_free(input isp_op_t op);
        return (op == ISP_OP_ENABLE) || (op == ISP_OP_END);
    endfunction

    function automatic logic is_fuse_write(input isp_op_t op);
        return (op == ISP_OP_WRITE_LOCK) || (op == ISP_OP_WRITE_FUSE_LO) ||
               (op == ISP_OP_WRITE_FUSE_HI) || (op == ISP_OP_WRITE_FUSE_EXT);
    endfunction

    // Blind wait after each write kind
    function automatic logic [`ISP_WAIT_W-1:0] wait_of(input isp_op_t op);
        case (op)
            ISP_OP_WRITE_PAGE:    return PAGE_WAIT_CYC;
            ISP_OP_WRITE_EE,
            ISP_OP_WRITE_EE_PAGE: return EE_WAIT_CYC;
            ISP_OP_ERASE:         return ERASE_WAIT_CYC;
            default:              return is_fuse_write(op) ? FUSE_WAIT_CYC : '0;
        endcase
    endfunction

    // Four instruction bytes, first byte sent first
    function automatic logic [31:0] frame_of(input isp_cmd_t c);
        logic [7:0] a_hi;
        logic [7:0] a_lo;
        logic [7:0] fd;
        a_hi = c.addr[15:8];
        a_lo = c.addr[7:0];
        fd   = c.data | UNUSED_MASK;
        case (c.op)
            ISP_OP_ENABLE:    return {`ISP_B1_PROG, `ISP_B2_ENABLE, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_ERASE:     return {`ISP_B1_PROG, `ISP_B2_ERASE, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_POLL:      return {`ISP_B1_POLL, `ISP_ZERO, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_LOAD_EXT:  return {`ISP_B1_LOAD_EXT, `ISP_ZERO, a_lo, `ISP_ZERO};
            ISP_OP_LOAD_LO:   return {`ISP_B1_LOAD_LO, `ISP_ZERO, {2'b00, a_lo[5:0]}, c.data};
            ISP_OP_LOAD_HI:   return {`ISP_B1_LOAD_HI, `ISP_ZERO, {2'b00, a_lo[5:0]}, c.data};
            ISP_OP_LOAD_EE:   return {`ISP_B1_LOAD_EE, `ISP_ZERO, {6'h00, a_lo[1:0]}, c.data};
            ISP_OP_READ_LO:   return {`ISP_B1_READ_LO, a_hi, a_lo, `ISP_ZERO};
            ISP_OP_READ_HI:   return {`ISP_B1_READ_HI, a_hi, a_lo, `ISP_ZERO};
            ISP_OP_READ_EE:   return {`ISP_B1_READ_EE, {6'h00, a_hi[1:0]}, a_lo, `ISP_ZERO};
            ISP_OP_READ_LOCK: return {`ISP_B1_READ_58, `ISP_ZERO, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_READ_SIG:  return {`ISP_B1_READ_SIG, `ISP_ZERO, {6'h00, a_lo[1:0]}, `ISP_ZERO};
            ISP_OP_READ_FUSE_LO:  return {`ISP_B1_READ_50, `ISP_ZERO, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_READ_FUSE_HI:  return {`ISP_B1_READ_58, `ISP_B2_SEL_HI, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_READ_FUSE_EXT: return {`ISP_B1_READ_50, `ISP_B2_SEL_HI, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_READ_CAL:  return {`ISP_B1_READ_CAL, `ISP_ZERO, `ISP_ZERO, `ISP_ZERO};
            ISP_OP_WRITE_PAGE: return {`ISP_B1_WRITE_PAGE, a_hi, a_lo, `ISP_ZERO};
            ISP_OP_WRITE_EE:  return {`ISP_B1_WRITE_EE, {6'h00, a_hi[1:0]}, a_lo, c.data};
            ISP_OP_WRITE_EE_PAGE:
                return {`ISP_B1_WRITE_EE_PG, {6'h00, a_hi[1:0]}, {a_lo[7:2], 2'b00}, `ISP_ZERO};
            ISP_OP_WRITE_LOCK:     return {`ISP_B1_PROG, `ISP_B2_LOCK, `ISP_ZERO, fd};
            ISP_OP_WRITE_FUSE_LO:  return {`ISP_B1_PROG, `ISP_B2_FUSE_LO, `ISP_ZERO, fd};
            ISP_OP_WRITE_FUSE_HI:  return {`ISP_B1_PROG, `ISP_B2_FUSE_HI, `ISP_ZERO, fd};
            ISP_OP_WRITE_FUSE_EXT: return {`ISP_B1_PROG, `ISP_B2_FUSE_EXT, `ISP_ZERO, fd};
            default:          return '0;
        endcase
    endfunction

    isp_sync u_miso_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .din   (miso),
        .dout  (miso_s)
    );

    isp_wait u_wait (
        .clk   (clk),
        .rst_n (rst_n),
        .load  (wait_load),
        .count (wait_count),
        .busy  (wait_busy)
    );

    assign take      = cmd_valid && ready_q;
    assign need_pwr  = take && (cmd.op == ISP_OP_ENABLE) && rst_out_q;
    // Closed session refuses everything but enable and end
    assign refuse    = take && !is_free(cmd.op) &&
                       (!enabled_q || ((cmd.op == ISP_OP_LOAD_HI) &&
                        !(lo_valid_q && (lo_addr_q == cmd.addr[5:0]))));
    assign start     = take && !refuse && !need_pwr && (cmd.op != ISP_OP_END);
    assign pwr_done  = (state_q == ISP_ST_PWRUP) && armed_q && !wait_busy;
    assign rstp_done = (state_q == ISP_ST_RSTP) && armed_q && !wait_busy;
    assign go        = start || (pwr_done && pend_q);
    assign go_cmd    = start ? cmd : cmd_q;
    assign go_frame  = frame_of(go_cmd);
    assign frame_end = (state_q == ISP_ST_SHIFT) && (ph_q == PH_LAST) && sck_q &&
                       (bit_q == BIT_LAST);
    assign echo_ok   = (rx_q[`ISP_ECHO_MSB:`ISP_ECHO_LSB] == `ISP_B2_ENABLE);

    always_comb begin
        wait_load  = 1'b0;
        wait_count = '0;
        case (state_q)
            ISP_ST_PWRUP: begin
                wait_load  = !armed_q;
                wait_count = STARTUP_CYC;
            end
            ISP_ST_RSTP: begin
                wait_load  = !armed_q;
                wait_count = RST_PULSE_CYC;
            end
            ISP_ST_DONE: begin
                wait_load  = (wait_of(cmd_q.op) != '0) && !cmd_q.poll;
                wait_count = wait_of(cmd_q.op);
            end
            default: begin
                wait_load  = 1'b0;
                wait_count = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= ISP_ST_PWRUP;
        end else begin
            case (state_q)
                ISP_ST_PWRUP: if (pwr_done) state_q <= pend_q ? ISP_ST_SHIFT : ISP_ST_IDLE;
                ISP_ST_IDLE: begin
                    if (go) begin
                        state_q <= ISP_ST_SHIFT;
                    end else if (need_pwr) begin
                        state_q <= ISP_ST_PWRUP;
                    end
                end
                ISP_ST_SHIFT: if (frame_end) state_q <= ISP_ST_DONE;
                ISP_ST_DONE: begin
                    // Bad echo means the link slipped a bit
                    if ((cmd_q.op == ISP_OP_ENABLE) && !echo_ok) begin
                        state_q <= ISP_ST_RSTP;
                    end else begin
                        state_q <= ISP_ST_IDLE;
                    end
                end
                ISP_ST_RSTP: if (rstp_done) state_q <= ISP_ST_PWRUP;
                default: state_q <= ISP_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            armed_q <= 1'b0;
            pend_q  <= 1'b0;
            cmd_q   <= '0;
        end else begin
            if (wait_load && (state_q != ISP_ST_DONE)) begin
                armed_q <= 1'b1;
            end else if (pwr_done || rstp_done) begin
                armed_q <= 1'b0;
            end
            if (need_pwr) begin
                pend_q <= 1'b1;
            end else if (pwr_done) begin
                pend_q <= 1'b0;
            end
            if (take) cmd_q <= cmd;
        end
    end

    // Target reset pin and session state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_out_q <= 1'b0;
            enabled_q <= 1'b0;
        end else if (take && (cmd.op == ISP_OP_END)) begin
            rst_out_q <= 1'b1;
            enabled_q <= 1'b0;
        end else if (need_pwr || rstp_done) begin
            rst_out_q <= 1'b0;
        end else if ((state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_ENABLE)) begin
            rst_out_q <= !echo_ok;
            enabled_q <= echo_ok;
        end
    end

    // Low-before-high bookkeeping for page loads
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            lo_valid_q <= 1'b0;
            lo_addr_q  <= '0;
        end else if (state_q == ISP_ST_DONE) begin
            if (cmd_q.op == ISP_OP_LOAD_LO) begin
                lo_valid_q <= 1'b1;
                lo_addr_q  <= cmd_q.addr[5:0];
            end else if ((cmd_q.op == ISP_OP_WRITE_PAGE) || (cmd_q.op == ISP_OP_ERASE) ||
                         (cmd_q.op == ISP_OP_LOAD_HI)) begin
                lo_valid_q <= 1'b0;
            end
        end
    end

    // Shifter: change data while clock low, sample just before falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sck_q  <= 1'b0;
            mosi_q <= 1'b0;
            tx_q   <= '0;
            rx_q   <= '0;
            ph_q   <= '0;
            bit_q  <= '0;
        end else if (go) begin
            tx_q   <= go_frame;
            mosi_q <= go_frame[31];
            sck_q  <= 1'b0;
            ph_q   <= '0;
            bit_q  <= '0;
        end else if (state_q == ISP_ST_SHIFT) begin
            if (ph_q != PH_LAST) begin
                ph_q <= ph_q + 1'b1;
            end else begin
                ph_q <= '0;
                if (!sck_q) begin
                    sck_q <= 1'b1;
                end else begin
                    // Target moved its bit at the last falling edge; sync delay fits the half
                    sck_q  <= 1'b0;
                    rx_q   <= {rx_q[30:0], miso_s};
                    tx_q   <= {tx_q[30:0], 1'b0};
                    mosi_q <= (bit_q == BIT_LAST) ? 1'b0 : tx_q[30];
                    bit_q  <= bit_q + 1'b1;
                end
            end
        end
    end

    // Command acceptance and answers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_q     <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_q       <= '0;
        end else begin
            ready_q     <= (state_q == ISP_ST_IDLE) && !wait_busy && !take;
            rsp_valid_q <= 1'b0;
            if (state_q == ISP_ST_DONE) begin
                rsp_valid_q     <= 1'b1;
                rsp_q.op        <= cmd_q.op;
                rsp_q.data      <= rx_q[7:0];
                rsp_q.echo_ok   <= echo_ok;
                rsp_q.busy      <= (cmd_q.op == ISP_OP_POLL) && rx_q[0];
                rsp_q.refused   <= 1'b0;
            end else if (refuse || (take && (cmd.op == ISP_OP_END))) begin
                rsp_valid_q     <= 1'b1;
                rsp_q.op        <= cmd.op;
                rsp_q.data      <= '0;
                rsp_q.echo_ok   <= 1'b0;
                rsp_q.busy      <= 1'b0;
                rsp_q.refused   <= refuse;
            end
        end
    end

    assign cmd_ready      = ready_q;
    assign rsp_valid      = rsp_valid_q;
    assign rsp            = rsp_q;
    assign session_active = enabled_q;
    assign target_rst_n   = rst_out_q;
    assign sck            = sck_q;
    assign mosi           = mosi_q;

    // Helper: cycles with target reset held low, and clock rises per frame
    logic [`ISP_WAIT_W-1:0] since_q;
    logic [5:0]             rises_q;
    always_ff @(posedge clk) begin
        if (!rst_n || rst_out_q) begin
            since_q <= '0;
        end else if (since_q != STARTUP_CYC) begin
            since_q <= since_q + 1'b1;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || go) begin
            rises_q <= '0;
        end else if ((state_q == ISP_ST_SHIFT) && !sck_q && (ph_q == PH_LAST)) begin
            rises_q <= rises_q + 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_mosi_stable: assert property ($rose(sck_q) |-> $stable(mosi_q))
        else $error("data changed on clock rise");
    chk_sck_low_idle: assert property (state_q != ISP_ST_SHIFT |-> !sck_q)
        else $error("clock high outside a frame");
    chk_rst_pulse: assert property (
        $rose(rst_out_q) && (state_q == ISP_ST_RSTP) |-> rst_out_q[*8])
        else $error("reset pulse too short");
    chk_startup_gap: assert property ($rose(sck_q) |-> since_q == STARTUP_CYC)
        else $error("frame before startup wait");
    chk_frame_bits: assert property (state_q == ISP_ST_DONE |-> rises_q == 6'd32)
        else $error("frame is not 32 clocks");
    chk_echo_retry: assert property (
        (state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_ENABLE) && !echo_ok
        |=> (state_q == ISP_ST_RSTP) && rst_out_q && !enabled_q)
        else $error("bad echo not followed by reset pulse");
    chk_page_wait: assert property (
        (state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_WRITE_PAGE) && !cmd_q.poll
        |=> !ready_q [*8])
        else $error("ready too soon after page write");
    chk_erase_wait: assert property (
        (state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_ERASE) && !cmd_q.poll
        |=> wait_busy ##1 !ready_q)
        else $error("no wait after chip erase");
    chk_refuse_closed: assert property (
        take && !enabled_q && !is_free(cmd.op) |=> rsp_valid_q && rsp_q.refused
        ##1 state_q == ISP_ST_IDLE)
        else $error("command not refused before enable");
    chk_hi_after_lo: assert property (
        take && (cmd.op == ISP_OP_LOAD_HI) && !lo_valid_q |=> rsp_q.refused)
        else $error("high byte load without low byte");
    chk_end_release: assert property (
        take && (cmd.op == ISP_OP_END) |=> rst_out_q && !enabled_q && rsp_valid_q)
        else $error("session end did not release reset");
    chk_fuse_unused: assert property (
        go && is_fuse_write(go_cmd.op) |-> (go_frame[7:0] & UNUSED_MASK) == UNUSED_MASK)
        else $error("unused fuse bit programmed");
    chk_poll_flag: assert property (
        (state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_POLL)
        |=> rsp_valid_q && (rsp_q.busy == $past(rx_q[0])))
        else $error("poll flag not returned");

    cov_enable_ok: cover property ((state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_ENABLE)
        && echo_ok);
    cov_echo_bad: cover property ((state_q == ISP_ST_RSTP) && rst_out_q);
    cov_page_write: cover property ((state_q == ISP_ST_DONE) && (cmd_q.op == ISP_OP_WRITE_PAGE));
    cov_refused: cover property (rsp_valid_q && rsp_q.refused);
endmodule // isp_host

// >>> isp_dev_model.sv
// Behavioural target device answering serial programming frames
`timescale 1ns/1ps
module isp_dev_model (
    input  wire logic target_rst_n,
    input  wire logic sck,
    input  wire logic mosi,
    output logic      miso
);
    logic [31:0] sr;
    logic [7:0]  ob;
    logic [7:0]  fl [64];
    logic [7:0]  pb [64];
    logic [7:0]  fz [2];
    logic        en;
    logic        m;
    logic        bz, sl;
    int          cnt;
    initial begin
        foreach (fl[i]) fl[i] = 8'hFF;
        foreach (pb[i]) pb[i] = 8'hFF;
        foreach (fz[i]) fz[i] = 8'hFF;
        {en, m, cnt, ob, sr} = '0;
        // First session is out of step, forcing one retry
        {bz, sl} = 2'h1;
    end
    // Released line inverts, so a stale level never passes
    assign miso = target_rst_n ? ~m : m;
    always @(posedge sck or posedge target_rst_n) begin
        if (target_rst_n) begin
            cnt = 0;
            en = 0;
            sl = 0;
        end else begin
            sr = {sr[30:0], mosi};
            cnt = cnt + 1;
            if (cnt == 16) ob = sl ? 8'h00 : sr[7:0];
            else if (cnt == 24) begin
                ob = (sr[23:16] == 8'h20) ? fl[sr[5:0]] : 8'h00;
                if (sr[23:8] == 16'h5000) ob = fz[0];
                if (sr[23:8] == 16'h5808) ob = fz[1];
                if (sr[23:16] == 8'hF0) ob = {7'h00, bz};
            end else if (cnt % 8 == 0) ob = 8'hFF;
            if (cnt == 32) begin
                cnt = 0;
                if (sr[31:16] == 16'hAC53) en = 1;
                else if (en && sr[31:24] == 8'h40) pb[sr[13:8]] = sr[7:0];
                else if (en && sr[31:24] == 8'h4C) begin
                    fl = pb;
                    bz = 1'b1;
                end else if (sr[31:24] == 8'hF0) bz = 1'b0;
                else if (en && sr[31:16] == 16'hAC80) foreach (fl[i]) fl[i] = 8'hFF;
                else if (en && sr[31:16] == 16'hACA0) fz[0] = sr[7:0];
            end
        end
    end
    always @(negedge sck) begin
        m <= ob[7];
        ob <= {ob[6:0], 1'b1};
    end
endmodule // isp_dev_model

// >>> isp_host_test.sv
// Self-checking bench for the serial programming host
`timescale 1ns/1ps
module isp_host_test;
    import isp_pkg::*;
    logic     clk, rst_n, cmd_valid, cmd_ready, rsp_valid, session_active;
    logic     target_rst_n, sck, mosi, miso;
    isp_cmd_t cmd;
    isp_rsp_t rsp;
    int       errors, checked, cyc;
    isp_host #(.STARTUP_CYC(23'h32), .PAGE_WAIT_CYC(23'h32), .EE_WAIT_CYC(23'h32),
        .ERASE_WAIT_CYC(23'h32), .FUSE_WAIT_CYC(23'h32), .UNUSED_MASK(8'h80)) DUT (
        .clk(clk), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd(cmd), .rsp(rsp), .cmd_ready(cmd_ready),
        .rsp_valid(rsp_valid), .session_active(session_active), .target_rst_n(target_rst_n),
        .sck(sck), .mosi(mosi), .miso(miso));
    isp_dev_model dev (.target_rst_n(target_rst_n), .sck(sck), .mosi(mosi), .miso(miso));
    task automatic give_verdict;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(logic [7:0] got, logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Request held until the edge that sees cmd_ready high
    task automatic run(isp_op_t op, logic [15:0] a, logic [7:0] d);
        int n;
        n = 0;
        cmd = '{op, a, d, 1'b0};
        cmd_valid = 1;
        while (cmd_ready !== 1'b1 && n < 2000) begin @(posedge clk); #1; n++; end
        @(posedge clk); #1;
        cmd_valid = 0;
        while (rsp_valid !== 1'b1 && n < 4000) begin @(posedge clk); #1; n++; end
        if (n >= 4000) chk(8'h00, 8'h01);
    endtask
    task automatic t_reset;
        repeat (20) @(posedge clk);
        #1;
        chk({target_rst_n, sck, cmd_ready}, 8'h00);
        rst_n = 1;
    endtask
    task automatic t_locked;
        run(ISP_OP_READ_LO, 16'h0003, 8'h00);
        chk(rsp.refused, 8'h01);
    endtask
    // Model starts out of step, so the first enable must be retried
    task automatic t_enable;
        run(ISP_OP_ENABLE, 16'h0000, 8'h00);
        chk({rsp.echo_ok, session_active, target_rst_n}, 8'h01);
        run(ISP_OP_ENABLE, 16'h0000, 8'h00);
        chk({rsp.echo_ok, session_active}, 8'h03);
    endtask
    task automatic t_page;
        run(ISP_OP_LOAD_LO, 16'h0003, 8'hA5);
        run(ISP_OP_WRITE_PAGE, 16'h0000, 8'h00);
        run(ISP_OP_POLL, 16'h0000, 8'h00);
        chk(rsp.busy, 8'h01);
        run(ISP_OP_POLL, 16'h0000, 8'h00);
        chk(rsp.busy, 8'h00);
        run(ISP_OP_READ_LO, 16'h0003, 8'h00);
        chk(rsp.data, 8'hA5);
        run(ISP_OP_READ_LO, 16'h0004, 8'h00);
        chk(rsp.data, 8'hFF);
        run(ISP_OP_ERASE, 16'h0000, 8'h00);
        run(ISP_OP_READ_LO, 16'h0003, 8'h00);
        chk(rsp.data, 8'hFF);
    endtask
    task automatic t_order;
        run(ISP_OP_LOAD_HI, 16'h0005, 8'h11);
        chk(rsp.refused, 8'h01);
    endtask
    // Unused top fuse bit is forced to one by the mask
    task automatic t_fuse;
        run(ISP_OP_WRITE_FUSE_LO, 16'h0000, 8'h62);
        run(ISP_OP_READ_FUSE_LO, 16'h0000, 8'h00);
        chk(rsp.data, 8'hE2);
        run(ISP_OP_READ_FUSE_HI, 16'h0000, 8'h00);
        chk(rsp.data, 8'hFF);
    endtask
    task automatic t_end;
        run(ISP_OP_END, 16'h0000, 8'h00);
        chk(8'(rsp.op), 8'(ISP_OP_END));
        @(posedge clk); #1;
        chk({target_rst_n, session_active}, 8'h02);
    endtask
    initial begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin errors++; give_verdict; end
    end
    initial begin
        {rst_n, cmd_valid, cmd, errors, checked, cyc} = '0;
        t_reset;
        t_locked;
        t_enable;
        t_page;
        t_order;
        t_fuse;
        t_end;
        give_verdict;
    end
endmodule // isp_host_test
